// ---- rtl/interrupt_vector_priority_unit.v ----
// interrupt vector and priority unit of a small 8-bit controller core
// assumes a core sequencer that asks at instruction end and an APB master
`include "irq_unit_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module interrupt_vector_priority_unit (
    input  wire        clk_in,
    input  wire        reset_n_in,
    input  wire        clk_en_in,
    // apb slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    // external lines, each a combined pin group
    input  wire [3:0]  ext_irq_line_in,
    input  wire [3:0]  ext_pin_low_in,
    // peripheral flags, bit 0 = source 7 .. bit 5 = source 12
    input  wire [5:0]  periph_flag_set_in,
    input  wire [5:0]  periph_seq_clear_in,
    // core sequencer
    input  wire        instr_end_in,
    input  wire        trap_exec_in,
    input  wire        interrupt_return_instruction_exec_in,
    input  wire        wait_mode_in,
    input  wire        halt_mode_in,
    output reg         irq_ack_out,
    output reg  [15:0] vector_addr_out,
    output reg         push_context_out,
    output reg         pop_context_out,
    output reg         mask_bit_out,
    output reg         wake_out
);

    localparam ST_RUN   = 2'd0;
    localparam ST_STACK = 2'd1;
    localparam ST_FETCH = 2'd2;

    // sequencer
    reg  [1:0] state_q;
    reg  [1:0] state_d;
    reg        trap_pend_q;
    reg  [3:0] win_src_q;

    // external lines
    reg  [7:0] sense_q;
    reg  [3:0] ext_pend_q;
    reg  [3:0] ext_prev_q;

    // peripheral sources
    reg  [5:0] periph_en_q;
    reg  [5:0] periph_flag_q;

    // apb: access phase starts the answer, the ready edge commits a write
    wire       apb_acc  = psel_in & penable_in & ~pready_out;
    wire       apb_done = psel_in & penable_in & pready_out;
    wire       apb_wr   = apb_done & pwrite_in;

    // address decode, one select per writable register word
    wire       sel_cc    = (paddr_in == `OFS_CONDITION_CODE);
    wire       sel_sense = (paddr_in == `OFS_EXT_SENSE);
    wire       sel_en    = (paddr_in == `OFS_PERIPH_ENABLE);
    wire       sel_flag  = (paddr_in == `OFS_PERIPH_FLAG);
    wire       sel_clr   = (paddr_in == `OFS_PERIPH_CLEAR);

    wire       sense_wr = apb_wr & sel_sense & mask_bit_out;
    wire       cc_wr    = apb_wr & sel_cc;
    wire       pf_wr    = apb_wr & sel_flag;
    wire       pc_wr    = apb_wr & sel_clr;
    wire       pe_wr    = apb_wr & sel_en;

    // per-line event detection and latch
    wire [3:0] ext_event;
    wire [3:0] ext_lvl;
    wire [3:0] ext_clr;
    wire [3:0] ext_src;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ext
            wire [1:0] code = sense_q[2*g+1:2*g];
            wire       cur  = ext_irq_line_in[g];
            wire       prv  = ext_prev_q[g];
            wire       rise = cur & ~prv;
            wire       fall = ~cur & prv;
            // a low pin of the group blocks the rising event in rise-only sensitivity
            wire       rise_ok = rise & ~ext_pin_low_in[g];
            reg        ev;
            always @* begin
                ev = 1'b0;
                case (code)
                    `SENSE_RISE: ev = rise_ok;
                    `SENSE_FALL: ev = fall;
                    `SENSE_BOTH: ev = rise | fall;
                    default:     ev = 1'b0;
                endcase
            end
            assign ext_event[g] = ev;
            assign ext_lvl[g] = (code == `SENSE_FALL_LOW) & ~cur;
            assign ext_clr[g] = sense_wr &
                (pwdata_in[2*g+1:2*g] != code);
            assign ext_src[g] = ext_pend_q[g] | ext_lvl[g];
        end
    endgenerate

    // request vector in priority order: bit 1..4 external, 7..12 periph
    wire [13:0] req;
    assign req[0]    = 1'b0;
    assign req[4:1]  = ext_src;
    assign req[6:5]  = 2'b00;
    assign req[12:7] = periph_flag_q & periph_en_q;
    assign req[13]   = 1'b0;

    // lowest pending source number wins
    reg  [3:0] win_d;
    reg        win_any;
    integer    i;
    always @* begin
        win_d   = 4'd0;
        win_any = 1'b0;
        for (i = 13; i >= 0; i = i - 1) begin
            if (req[i]) begin
                win_d   = i[3:0];
                win_any = 1'b1;
            end
        end
    end

    wire take_trap = trap_pend_q | trap_exec_in;
    wire take_mask = win_any & ~mask_bit_out;
    wire accept    = (state_q == ST_RUN) & instr_end_in &
                     (take_trap | take_mask);

    // halt wake: any external line, or an enabled halt-capable flag
    wire       ext_any    = |ext_src;
    wire [5:0] periph_req = req[12:7];
    wire       halt_per   = |(periph_req & `HALT_WAKE_PERIPH);
    wire       halt_ok    = ext_any | halt_per;

    // sequencer next state: no new accept while stacking and fetching
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (accept) begin
                    state_d = ST_STACK;
                end
            end
            ST_STACK: begin
                state_d = ST_FETCH;
            end
            ST_FETCH: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // read mux, unmapped words read as zero
    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h0;
        case (paddr_in)
            `OFS_CONDITION_CODE: rd_d = {31'h0, mask_bit_out};
            `OFS_EXT_SENSE:      rd_d = {24'h0, sense_q};
            `OFS_PERIPH_ENABLE:  rd_d = {26'h0, periph_en_q};
            `OFS_PERIPH_FLAG:    rd_d = {26'h0, periph_flag_q};
            `OFS_PERIPH_CLEAR:   rd_d = 32'h0;
            `OFS_CORE_STATUS:    rd_d = {26'h0, state_q, win_src_q};
            `OFS_LINE_STATE:     rd_d = {24'h0, ext_pend_q, ext_src};
            default:             rd_d = 32'h0;
        endcase
    end
    wire unmapped = (paddr_in > `OFS_LINE_STATE) | (paddr_in[1:0] != 2'b00);

    // one-hot clear of the external line entered at this accept
    reg  [3:0] ext_take;
    always @* begin
        ext_take = 4'h0;
        if (accept & ~take_trap) begin
            case (win_d)
                4'd1:    ext_take = 4'b0001;
                4'd2:    ext_take = 4'b0010;
                4'd3:    ext_take = 4'b0100;
                4'd4:    ext_take = 4'b1000;
                default: ext_take = 4'h0;
            endcase
        end
    end

    // software clears: write 0 to the flag word, or 1 to the clear word
    wire [5:0] pf_zero_clr = pf_wr ? ~pwdata_in[5:0] : 6'h00;
    wire [5:0] pc_one_clr  = pc_wr ? pwdata_in[5:0] : 6'h00;

    // vector of the winner: two bytes per source below source 0
    wire [15:0] vec_d     = take_trap ? `VEC_TRAP :
                            (`VEC_SRC0 - {11'h0, win_d, 1'b0});
    wire [3:0]  win_tag_d = take_trap ? 4'hF : win_d;
    wire        ret_take  = interrupt_return_instruction_exec_in & (state_q == ST_RUN) & ~accept;

    // wake conditions
    wire        wait_wake = wait_mode_in & (win_any | take_trap);
    wire        halt_wake = halt_mode_in & halt_ok;

    // apb response: ready one cycle after the access phase starts
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prdata_out  <= 32'h0;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else if (clk_en_in) begin
            pready_out  <= apb_acc;
            pslverr_out <= apb_acc & unmapped;
            if (apb_acc & ~pwrite_in) begin
                prdata_out <= rd_d;
            end
        end
    end

    // sequencer state and a trap held until a boundary comes
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q     <= ST_RUN;
            trap_pend_q <= 1'b0;
        end else if (clk_en_in) begin
            state_q <= state_d;
            if (trap_exec_in & ~accept) begin
                trap_pend_q <= 1'b1;
            end else if (accept & take_trap) begin
                trap_pend_q <= 1'b0;
            end
        end
    end

    // external lines: previous level, sensitivity, edge latch
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ext_prev_q <= 4'hF;
            sense_q    <= `RST_EXT_SENSE;
            ext_pend_q <= 4'h0;
        end else if (clk_en_in) begin
            ext_prev_q <= ext_irq_line_in;
            if (sense_wr) begin
                sense_q <= pwdata_in[7:0];
            end
            // a new edge wins over a clear in the same cycle
            ext_pend_q <= (ext_pend_q & ~ext_clr & ~ext_take)
                          | ext_event;
        end
    end

    // peripheral enables and flags; a new flag wins over a clear
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            periph_en_q   <= `RST_PERIPH_ENABLE;
            periph_flag_q <= 6'h00;
        end else if (clk_en_in) begin
            if (pe_wr) begin
                periph_en_q <= pwdata_in[5:0];
            end
            periph_flag_q <= (periph_flag_q & ~pf_zero_clr & ~pc_one_clr
                              & ~periph_seq_clear_in)
                             | periph_flag_set_in;
        end
    end

    // core handshake: acknowledge, push, vector, mask and return
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mask_bit_out     <= `RST_MASK_BIT;
            win_src_q        <= 4'h0;
            irq_ack_out      <= 1'b0;
            vector_addr_out  <= `VEC_RESET;
            push_context_out <= 1'b0;
            pop_context_out  <= 1'b0;
        end else if (clk_en_in) begin
            irq_ack_out      <= accept;
            push_context_out <= accept;
            pop_context_out  <= ret_take;
            if (accept) begin
                mask_bit_out    <= 1'b1;
                win_src_q       <= win_tag_d;
                vector_addr_out <= vec_d;
            end else if (ret_take) begin
                mask_bit_out <= 1'b0;
            end else if (cc_wr) begin
                mask_bit_out <= pwdata_in[0];
            end
        end
    end

    // wake request: any source in wait, halt-capable ones in halt
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wake_out <= 1'b0;
        end else if (clk_en_in) begin
            wake_out <= wait_wake | halt_wake;
        end
    end

endmodule

`default_nettype wire

// ---- rtl/irq_unit_regs.vh ----
// constants for the interrupt vector and priority unit
// assumes an APB slave with 32-bit words and a 100 MHz clock
`ifndef IRQ_UNIT_REGS_VH
`define IRQ_UNIT_REGS_VH

// register byte offsets
`define OFS_CONDITION_CODE   12'h000
`define OFS_EXT_SENSE        12'h004
`define OFS_PERIPH_ENABLE    12'h008
`define OFS_PERIPH_FLAG      12'h00C
`define OFS_PERIPH_CLEAR     12'h010
`define OFS_CORE_STATUS      12'h014
`define OFS_LINE_STATE       12'h018

// reset values
`define RST_MASK_BIT         1'b1
`define RST_EXT_SENSE        8'h00
`define RST_PERIPH_ENABLE    6'h00

// sensitivity codes
`define SENSE_FALL_LOW       2'b00
`define SENSE_RISE           2'b01
`define SENSE_FALL           2'b10
`define SENSE_BOTH           2'b11

// vectors
`define VEC_RESET            16'hFFFE
`define VEC_TRAP             16'hFFFC
`define VEC_SRC0             16'hFFFA

// halt-capable peripheral sources (source 7..12, bit 0 = source 7)
`define HALT_WAKE_PERIPH     6'b110100

// peripheral sources are 7..12
`define PERIPH_FIRST         4'd7
`define NUM_PERIPH           6

`endif

// ---- test/irq_unit_sva.sv ----
// assertions on the ports of the interrupt vector and priority unit
// assumes clk_en_in held high by the bench
`timescale 1ns/1ps
`default_nettype none
module irq_unit_sva (
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pready_out,
    input wire logic        instr_end_in,
    input wire logic        trap_exec_in,
    input wire logic        interrupt_return_instruction_exec_in,
    input wire logic        irq_ack_out,
    input wire logic        push_context_out,
    input wire logic        pop_context_out,
    input wire logic        mask_bit_out,
    input wire logic [15:0] vector_addr_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_pop;
        ##[1:2] pop_context_out;
    endsequence
    AST_RST_MASK: assert property ($rose(reset_n_in) |-> mask_bit_out)
        else $error("mask clear after reset");
    AST_ACK_CAUSE: assert property (irq_ack_out |-> $past(instr_end_in)
        && ($past(trap_exec_in) || !$past(mask_bit_out)))
        else $error("accept without boundary or with mask set");
    AST_ACK_PUSH: assert property (irq_ack_out |-> push_context_out)
        else $error("no context push at accept");
    AST_ACK_MASK: assert property (irq_ack_out |-> mask_bit_out)
        else $error("mask not set at accept");
    AST_INTERRUPT_RETURN_INSTRUCTION_POP: assert property (interrupt_return_instruction_exec_in |-> s_pop)
        else $error("no context pop after return");
    AST_VEC_MAP: assert property (irq_ack_out |-> !vector_addr_out[0]
        && vector_addr_out >= 16'hFFE0 && vector_addr_out != 16'hFFFE)
        else $error("vector outside the table");
    AST_TRAP_VEC: assert property (irq_ack_out && $past(trap_exec_in)
        |-> vector_addr_out == 16'hFFFC)
        else $error("trap vector wrong");
    AST_ACK_PULSE: assert property (irq_ack_out |=> !irq_ack_out)
        else $error("ack longer than one cycle");
    AST_VEC_HOLD: assert property (!irq_ack_out |-> $stable(vector_addr_out))
        else $error("vector moved without accept");
    AST_APB_READY: assert property (psel_in && penable_in && !pready_out
        |=> pready_out)
        else $error("no ready after access");
endmodule
`default_nettype wire

// ---- test/core_seq_model.sv ----
// core sequencer model: boundaries, handler busy time, return pulse
// assumes the bench asks for the return once the handler is done
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic run_in,
    input  wire logic ack_in,
    input  wire logic interrupt_return_instruction_go_in,
    output var  logic instr_end_out,
    output var  logic interrupt_return_instruction_out
);
    logic busy_q;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_q <= 1'b0;
            interrupt_return_instruction_out <= 1'b0;
        end else begin
            interrupt_return_instruction_out <= interrupt_return_instruction_go_in & busy_q;
            if (ack_in) busy_q <= 1'b1;
            else if (interrupt_return_instruction_out) busy_q <= 1'b0;
        end
    end
    assign instr_end_out = run_in & ~busy_q;
endmodule
`default_nettype wire

// ---- test/interrupt_vector_priority_unit_bench.sv ----
// self-checking bench for the interrupt vector and priority unit
// assumes the core model file and the checker file are compiled first
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_priority_unit_bench;
    logic clk_in = 0, reset_n_in = 0, psel = 0, pen = 0, pwr = 0, run = 0;
    logic ig = 0, trap = 0, wm = 0, ie, interrupt_return_instruction, rdy, err, ack, g, pe;
    logic push, pop, mask, wake, hm = 0;
    logic [11:0] pa = 0;
    logic [3:0]  pl = 0;
    logic [31:0] pwd = 0, prd, rd;
    logic [15:0] vec;
    logic [3:0]  ext = 4'hF;
    logic [5:0]  fset = 0, sclr = 0;
    int n_errors = 0, n_checks = 0, cyc = 0, pend, s, k;
    always #5 clk_in = ~clk_in;
    interrupt_vector_priority_unit dut_u (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .clk_en_in(1'b1), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(rdy), .pslverr_out(err),
        .ext_irq_line_in(ext), .ext_pin_low_in(pl),
        .periph_flag_set_in(fset), .periph_seq_clear_in(sclr),
        .instr_end_in(ie), .trap_exec_in(trap), .interrupt_return_instruction_exec_in(interrupt_return_instruction),
        .wait_mode_in(wm), .halt_mode_in(hm), .irq_ack_out(ack),
        .vector_addr_out(vec), .push_context_out(push),
        .pop_context_out(pop), .mask_bit_out(mask), .wake_out(wake));
    core_seq_model core_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .run_in(run), .ack_in(ack), .interrupt_return_instruction_go_in(ig),
        .instr_end_out(ie), .interrupt_return_instruction_out(interrupt_return_instruction));
    task conclude;
        if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk_in);
        pen <= 1;
        do @(posedge clk_in); while (rdy !== 1'b1);
        rd = prd;
        pe = err;
        psel <= 0; pen <= 0;
    endtask
    task wack;
        for (k = 0; k < 30 && ack !== 1'b1; k++) @(negedge clk_in);
        g = (ack === 1'b1);
    endtask
    task ret;
        @(posedge clk_in) ig <= 1;
        @(posedge clk_in) ig <= 0;
    endtask
    task pulse(input logic [5:0] f, input logic [5:0] c);
        @(posedge clk_in) begin fset <= f; sclr <= c; end
        @(posedge clk_in) begin fset <= 0; sclr <= 0; end
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            conclude;
        end
    end
    initial begin
        void'($urandom(32'h8E511B95));
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1;
        apb(0, 12'h000, 0);
        chk(rd[0], 1);
        chk(vec, 16'hFFFE);
        apb(0, 12'h020, 0);
        chk(pe, 1);
        apb(1, 12'h008, 32'h3F);
        pend = ($urandom & 32'h3F) | 32'h06;
        run <= 1;
        pulse(pend[5:0], 0);
        wack;
        chk(g, 0);
        run <= 0; wm <= 1;
        apb(1, 12'h000, 0);
        repeat (3) @(negedge clk_in);
        chk(wake, 1);
        wm <= 0; hm <= 1;
        repeat (3) @(negedge clk_in);
        chk(wake, 1);
        hm <= 0; run <= 1;
        while (pend != 0) begin
            wack;
            chk(g, 1);
            for (s = 0; !pend[s]; s++) ;
            chk(vec, 16'hFFFA - 2 * (s + 7));
            apb(1, 12'h010, 1 << s);
            pend &= ~(1 << s);
            ret;
        end
        apb(1, 12'h000, 1);
        @(posedge clk_in) trap <= 1;
        @(posedge clk_in) trap <= 0;
        wack;
        chk(vec, 16'hFFFC);
        ret;
        apb(1, 12'h004, 32'h55);
        apb(0, 12'h004, 0);
        chk(rd[7:0], 0);
        apb(1, 12'h000, 1);
        apb(1, 12'h004, 32'h55);
        apb(0, 12'h004, 0);
        chk(rd[7:0], 8'h55);
        apb(1, 12'h000, 0);
        for (s = 0; s < 4; s++) begin
            @(posedge clk_in) ext[s] <= 0;
            @(posedge clk_in) ext[s] <= 1;
            wack;
            chk(vec, 16'hFFF8 - 2 * s);
            ret;
            wack;
            chk(g, 0);
        end
        @(posedge clk_in) pl <= 4'h1;
        @(posedge clk_in) ext[0] <= 0;
        @(posedge clk_in) ext[0] <= 1;
        wack;
        chk(g, 0);
        @(posedge clk_in) pl <= 4'h0;
        apb(1, 12'h000, 1);
        apb(1, 12'h008, 0);
        pulse(6'h01, 0);
        pulse(0, 6'h01);
        apb(1, 12'h008, 32'h01);
        apb(1, 12'h000, 0);
        wack;
        chk(g, 0);
        conclude;
    end
endmodule
bind interrupt_vector_priority_unit irq_unit_sva sva_u (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pready_out(pready_out), .instr_end_in(instr_end_in),
    .trap_exec_in(trap_exec_in), .interrupt_return_instruction_exec_in(interrupt_return_instruction_exec_in),
    .irq_ack_out(irq_ack_out), .push_context_out(push_context_out),
    .pop_context_out(pop_context_out), .mask_bit_out(mask_bit_out),
    .vector_addr_out(vector_addr_out));
`default_nettype wire
